// ==== design/txbp_parser.sv ====
// Overview of operation
// R1: buffer size field gives payload byte count following the commands
// R2: size plus alignment setting gives trailing filler dwords to discard
// R3: running buffer size sum compared to packet length, mismatch sets error
// R4: packet length excludes offset and padding; mismatch sets error
// R5: tag from second word copied to output unchanged
// R6: crc-disable bit suppresses crc append
// R7: pad-disable bit suppresses short-frame padding to 64 bytes
// R8: pad disabled forces crc append regardless of crc-disable
// R9: data begins at third dword after the two command words
// R10: offset low bits select first valid byte lane
// R11: offset upper bits skip zero to seven leading dwords
// R12: buffer ends on any byte; unused trailing bytes not forwarded
// R13: alignment 4, 16 or 32 bytes; filler discarded automatically
// R14: host appends filler to reach the end alignment
// R15: buffers may start and end on any byte alignment
// R16: host keeps middle buffers at least four bytes long
// R17: downstream fifo holds a whole packet before transmission
// R18: host keeps per-packet fifo usage within the byte budget
// R19: whole offset and alignment dwords stripped before loading fifo
// R20: both command words discarded, never forwarded
// R21: host may limit a packet to 86 buffers
// R22: first word bit 13 flags first segment, bit 12 last segment
// R23: differing second command words within a packet set error
// R24: length check on last-segment buffer, then sum cleared
// R25: error flag sticky until software clear; traffic continues
`timescale 1ns/10ps
`default_nettype none

// ************************************************************
// byte fifo
// ************************************************************
module txbp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input  wire logic             clk,
   input  wire logic             sys_rst,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic [WIDTH-1:0]      out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wp_q;
   logic [AW-1:0]    rp_q;
   logic [AW:0]      cnt_q;
   wire              push = in_valid && in_ready;
   wire              pop  = out_valid && out_ready;

   // full is a count equal to the depth; the count is one bit wider than the pointers
   assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rp_q];

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) wp_q <= wp_q + 1'b1;
         if (pop) rp_q <= rp_q + 1'b1;
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   always_ff @(posedge clk) begin
      if (push) mem_q[wp_q] <= in_data;
   end

   // occupancy past the depth would overwrite a byte not yet read
   a_fifo_bound: assert property (@(posedge clk) disable iff (sys_rst) // [R17]
      cnt_q <= (AW+1)'(DEPTH)) else $error("fifo overfilled");
endmodule : txbp_fifo

// ************************************************************
// command parser
// ************************************************************
module txbp_parser
   import txbp_pkg::*;
(
   input  wire logic         clk,
   input  wire logic         sys_rst,
   input  wire logic [31:0]  host_data,
   input  wire logic         host_valid,
   output logic              host_ready,
   input  wire logic         tx_error_clear,
   output logic              tx_error_flag,
   output txbp_pkg::txbp_byte_t mac_byte,
   output logic              mac_valid,
   input  wire logic         mac_ready,
   output logic              mac_add_crc,
   output logic              mac_add_pad
);
   import txbp_pkg::*;

   txbp_state_t      st_q;
   logic [31:0]      cmda_q;
   logic [31:0]      cmdb_q;
   logic [31:0]      pktb_q;
   logic             inpkt_q;
   logic [LEN_W-1:0] sum_q;
   logic [LEN_W-1:0] left_q;
   logic [7:0]       skip_q;
   logic [7:0]       pad_q;
   logic [31:0]      word_q;
   logic [2:0]       lane_q;
   logic             busy_q;
   logic             firstb_q;
   logic             err_q;
   logic             crc_q;
   logic             padq_q;

   // ************************************************************
   // decode of command word a
   // ************************************************************
   wire [LEN_W-1:0] a_size  = host_data[A_SIZE_MSB:A_SIZE_LSB];            // [R1]
   wire [4:0]       a_ofs   = host_data[A_OFS_MSB:A_OFS_LSB];
   wire [1:0]       a_align = host_data[A_ALIGN_MSB:A_ALIGN_LSB];
   wire             a_first = host_data[A_FIRST_BIT];                      // [R22]
   wire [LEN_W+4:0] a_span  = {5'h00, a_size} + {11'h000, a_ofs};
   // aligned end in bytes: size plus offset rounded up to the alignment [R2] [R13]
   wire [LEN_W+4:0] a_amask = (a_align == ALIGN_32) ? 16'h001f :
                              (a_align == ALIGN_16) ? 16'h000f : 16'h0003;
   wire [LEN_W+4:0] a_end   = (a_span + a_amask) & ~a_amask;
   wire [LEN_W+4:0] a_used  = (a_span + 16'h0003) & ~16'h0003;
   wire [7:0]       a_tail  = 8'((a_end - a_used) >> 2);                   // [R2]
   wire [7:0]       a_skip  = {5'h00, a_ofs[4:2]};                        // [R11]

   // ************************************************************
   // word and byte stepping
   // ************************************************************
   wire word_take = host_valid && host_ready;
   wire fifo_ready;
   wire byte_go   = busy_q && (left_q != LEN_ZERO);
   wire byte_push = byte_go && fifo_ready;
   wire last_byte = (left_q == LEN_W'(1));
   wire lane_end  = (lane_q == 3'h3) || last_byte;
   wire [7:0] lane_byte = word_q[8*lane_q[1:0] +: 8];                      // [R10]
   wire       pkt_last  = cmda_q[A_LAST_BIT];                              // [R22]
   wire [LEN_W-1:0] sum_nx = sum_q + cmda_q[A_SIZE_MSB:A_SIZE_LSB];        // [R3]
   wire b_differs = inpkt_q && (host_data != pktb_q);                      // [R23]
   wire len_bad   = (sum_nx != cmdb_q[B_LEN_MSB:B_LEN_LSB]);               // [R4]
   wire buf_done  = byte_push && last_byte;
   wire err_set   = (st_q == ST_CMDB && word_take && b_differs) ||
                    (buf_done && pkt_last && len_bad);                     // [R24]

   assign host_ready = (st_q == ST_CMDA) || (st_q == ST_CMDB) ||
                       (st_q == ST_PAD) || (st_q == ST_DATA && !busy_q);

   txbp_byte_t fin;
   assign fin.data   = lane_byte;
   assign fin.first  = firstb_q;
   assign fin.last   = last_byte && pkt_last;
   assign fin.no_crc = cmdb_q[B_NOCRC_BIT];
   assign fin.no_pad = cmdb_q[B_NOPAD_BIT];
   assign fin.tag    = cmdb_q[B_TAG_MSB:B_TAG_LSB];                        // [R5]

   // store-and-forward is the mac's job; this fifo only absorbs rate [R17]
   txbp_fifo #(.WIDTH($bits(txbp_byte_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .in_data   (fin),
      .in_valid  (byte_go),
      .in_ready  (fifo_ready),
      .out_data  (mac_byte),
      .out_valid (mac_valid),
      .out_ready (mac_ready)
   );

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_q     <= ST_CMDA;
         cmda_q   <= 32'h0000_0000;
         cmdb_q   <= 32'h0000_0000;
         pktb_q   <= 32'h0000_0000;
         inpkt_q  <= 1'b0;
         sum_q    <= LEN_ZERO;
         left_q   <= LEN_ZERO;
         skip_q   <= 8'h00;
         pad_q    <= 8'h00;
         word_q   <= 32'h0000_0000;
         lane_q   <= 3'h0;
         busy_q   <= 1'b0;
         firstb_q <= 1'b0;
      end else begin
         unique case (st_q)
            ST_CMDA: if (word_take) begin                                  // [R20]
               cmda_q <= host_data;
               left_q <= a_size;
               skip_q <= a_skip;
               pad_q  <= a_tail;
               lane_q <= {1'b0, a_ofs[1:0]};
               if (a_first) inpkt_q <= 1'b0;
               st_q   <= ST_CMDB;
            end
            ST_CMDB: if (word_take) begin                                  // [R9]
               cmdb_q  <= host_data;
               firstb_q <= cmda_q[A_FIRST_BIT];
               if (!inpkt_q) pktb_q <= host_data;
               inpkt_q <= 1'b1;
               st_q    <= (left_q == LEN_ZERO) ?
                          ((pad_q == 8'h00) ? ST_CMDA : ST_PAD) : ST_DATA;
            end
            ST_DATA: begin
               if (word_take) begin
                  if (skip_q != 8'h00) skip_q <= skip_q - 1'b1;            // [R11] [R19]
                  else begin
                     word_q <= host_data;
                     busy_q <= 1'b1;
                  end
               end
               if (byte_push) begin                                        // [R12] [R15]
                  firstb_q <= 1'b0;
                  left_q   <= left_q - 1'b1;
                  lane_q   <= lane_end ? 3'h0 : lane_q + 1'b1;
                  if (lane_end) busy_q <= 1'b0;
                  if (last_byte) begin
                     sum_q <= pkt_last ? LEN_ZERO : sum_nx;                // [R24]
                     if (pkt_last) inpkt_q <= 1'b0;
                     st_q  <= (pad_q == 8'h00) ? ST_CMDA : ST_PAD;
                  end
               end
            end
            ST_PAD: if (word_take) begin                                   // [R13] [R19]
               pad_q <= pad_q - 1'b1;
               if (pad_q == 8'h01) st_q <= ST_CMDA;
            end
         endcase
      end
   end

   // ************************************************************
   // error flag and frame options
   // ************************************************************
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         err_q  <= 1'b0;
         crc_q  <= 1'b1;
         padq_q <= 1'b1;
      end else begin
         if (err_set) err_q <= 1'b1;                                       // [R25]
         else if (tx_error_clear) err_q <= 1'b0;
         // no-pad forces crc; padding targets MIN_FRAME bytes downstream
         crc_q  <= !cmdb_q[B_NOCRC_BIT] || cmdb_q[B_NOPAD_BIT];            // [R6] [R8]
         padq_q <= !cmdb_q[B_NOPAD_BIT];                                   // [R7]
      end
   end

   assign tx_error_flag = err_q;
   assign mac_add_crc   = crc_q;
   assign mac_add_pad   = padq_q;

   // ************************************************************
   // checks
   // ************************************************************
   a_err_sticky: assert property (@(posedge clk) disable iff (sys_rst)
      err_q && !tx_error_clear |=> err_q) else $error("error flag dropped"); // [R25]
   a_err_len: assert property (@(posedge clk) disable iff (sys_rst)
      buf_done && pkt_last && len_bad |=> err_q) else $error("length miss"); // [R4]
   a_err_tagb: assert property (@(posedge clk) disable iff (sys_rst)
      st_q == ST_CMDB && word_take && b_differs |=> err_q)
      else $error("cmd b mismatch missed");                                // [R23]
   a_sum_clear: assert property (@(posedge clk) disable iff (sys_rst)
      buf_done && pkt_last |=> sum_q == LEN_ZERO) else $error("sum kept"); // [R24]
   a_crc_force: assert property (@(posedge clk) disable iff (sys_rst)
      cmdb_q[B_NOPAD_BIT] |=> mac_add_crc) else $error("crc not forced");  // [R8]
   a_crc_off: assert property (@(posedge clk) disable iff (sys_rst)
      cmdb_q[B_NOCRC_BIT] && !cmdb_q[B_NOPAD_BIT] |=> !mac_add_crc)
      else $error("crc not disabled");                                     // [R6]
   a_pad_off: assert property (@(posedge clk) disable iff (sys_rst)
      cmdb_q[B_NOPAD_BIT] |=> !mac_add_pad) else $error("pad not off");    // [R7]
   a_no_cmd_out: assert property (@(posedge clk) disable iff (sys_rst)
      byte_go |-> st_q == ST_DATA) else $error("byte outside data");       // [R20]
   a_tag_copy: assert property (@(posedge clk) disable iff (sys_rst)
      byte_go |-> fin.tag == cmdb_q[B_TAG_MSB:B_TAG_LSB]) else $error("tag"); // [R5]
   a_count_down: assert property (@(posedge clk) disable iff (sys_rst)
      byte_push |=> left_q == $past(left_q) - 1'b1) else $error("count");  // [R1]

   // whole offset dwords must be spent before any byte is cut from a word
   a_skip_first: assert property (@(posedge clk) disable iff (sys_rst) // [R11]
      byte_go |-> skip_q == 8'h00) else $error("byte before skip done");
   a_pad_no_byte: assert property (@(posedge clk) disable iff (sys_rst) // [R19]
      st_q == ST_PAD |-> !byte_go) else $error("filler forwarded");
   a_first_once: assert property (@(posedge clk) disable iff (sys_rst) // [R22]
      byte_push && firstb_q |=> !firstb_q) else $error("first mark repeated");

   c_buf_done: cover property (@(posedge clk) disable iff (sys_rst) buf_done && pkt_last);
   c_pad_skip: cover property (@(posedge clk) disable iff (sys_rst) st_q == ST_PAD);
   c_err:      cover property (@(posedge clk) disable iff (sys_rst) err_set);
   c_stall:    cover property (@(posedge clk) disable iff (sys_rst) byte_go && !fifo_ready);
endmodule : txbp_parser
`default_nettype wire

// ==== inc/txbp_pkg.sv ====
package txbp_pkg;
   // ************************************************************
   // command word field layout
   // ************************************************************
   localparam int A_SIZE_LSB   = 0;
   localparam int A_SIZE_MSB   = 10;
   localparam int A_LAST_BIT   = 12;
   localparam int A_FIRST_BIT  = 13;
   localparam int A_OFS_LSB    = 16;
   localparam int A_OFS_MSB    = 20;
   localparam int A_ALIGN_LSB  = 24;
   localparam int A_ALIGN_MSB  = 25;
   localparam int B_LEN_LSB    = 0;
   localparam int B_LEN_MSB    = 10;
   localparam int B_NOPAD_BIT  = 12;
   localparam int B_NOCRC_BIT  = 13;
   localparam int B_TAG_LSB    = 16;
   localparam int B_TAG_MSB    = 31;

   // ************************************************************
   // sizes and encodings
   // ************************************************************
   localparam int LEN_W        = 11;
   localparam int FIFO_DEPTH   = 8;
   localparam int MIN_FRAME    = 64;
   localparam logic [1:0] ALIGN_4  = 2'h0;
   localparam logic [1:0] ALIGN_16 = 2'h1;
   localparam logic [1:0] ALIGN_32 = 2'h2;
   localparam logic [LEN_W-1:0] LEN_ZERO = 11'h000;

   typedef struct packed {
      logic [7:0] data;
      logic       first;
      logic       last;
      logic       no_crc;
      logic       no_pad;
      logic [15:0] tag;
   } txbp_byte_t;

   typedef enum logic [3:0] {
      ST_CMDA = 4'h1,
      ST_CMDB = 4'h2,
      ST_DATA = 4'h4,
      ST_PAD  = 4'h8
   } txbp_state_t;
endpackage : txbp_pkg

// ==== tb/tx_buffer_command_parser_test.sv ====
`timescale 1ns/10ps
`default_nettype none
module tx_buffer_command_parser_test;
   import txbp_pkg::*;
   logic        clk, sys_rst, host_valid, host_ready, tx_error_clear, tx_error_flag;
   logic        mac_valid, mac_ready, mac_add_crc, mac_add_pad;
   logic [31:0] host_data;
   txbp_byte_t  mac_byte;
   int          miscompares, n_compared;
   logic [7:0]  exp_q[$];
   txbp_byte_t  got_q[$];

   txbp_parser u_txbp_parser (.clk(clk), .sys_rst(sys_rst), .host_data(host_data),
      .host_valid(host_valid), .host_ready(host_ready), .tx_error_clear(tx_error_clear),
      .tx_error_flag(tx_error_flag), .mac_byte(mac_byte), .mac_valid(mac_valid),
      .mac_ready(mac_ready), .mac_add_crc(mac_add_crc), .mac_add_pad(mac_add_pad));
   txbp_host_model u_host (.clk(clk), .host_ready(host_ready), .host_data(host_data),
      .host_valid(host_valid));

   always #4 clk = ~clk;
   always @(posedge clk) if (mac_valid === 1'b1 && mac_ready === 1'b1) got_q.push_back(mac_byte);

   // ************************************************************
   // compare and access tasks
   // ************************************************************
   task automatic chk_val(input string what, input logic [15:0] e, g);
      n_compared++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, e, g);
      end
   endtask : chk_val

   task automatic chk_bit(input string what, input logic e, g);
      chk_val(what, {15'h0, e}, {15'h0, g});
   endtask : chk_bit

   function automatic logic [31:0] cmdb(logic [15:0] t, logic nc, np, int len);
      return {t, 2'h0, nc, np, 1'b0, 11'(len)};
   endfunction : cmdb

   task automatic buf_tx(input logic fs, ls, input int ofs, size, al,
                         input logic [31:0] b, input logic [7:0] seed);
      u_host.send_buf(fs, ls, ofs, size, al, b, seed);
      for (int i = 0; i < size; i++) exp_q.push_back(seed + 8'(i));
   endtask : buf_tx

   task automatic drain(input logic [15:0] tag);
      int         t;
      int         idx;
      txbp_byte_t g;
      u_host.idle();
      idx = 0;
      t = 0;
      while (got_q.size() < exp_q.size() && t < 400) begin
         @(posedge clk);
         t++;
      end
      repeat (4) @(posedge clk);
      chk_val("byte count", 16'(exp_q.size()), 16'(got_q.size()));
      while (exp_q.size() > 0 && got_q.size() > 0) begin
         g = got_q.pop_front();
         chk_val("payload byte", {8'h00, exp_q.pop_front()}, {8'h00, g.data});
         chk_val("tag", tag, g.tag);
         chk_bit("first mark", idx == 0, g.first);
         chk_bit("last mark", exp_q.size() == 0, g.last);
         idx++;
      end
      exp_q.delete();
      got_q.delete();
   endtask : drain

   task automatic clear_err();
      tx_error_clear <= 1'b1;
      @(posedge clk);
      tx_error_clear <= 1'b0;
      repeat (2) @(posedge clk);
      chk_bit("error after clear", 1'b0, tx_error_flag);
   endtask : clear_err

   task automatic stop_test();
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : stop_test

   // ************************************************************
   // tests
   // ************************************************************
   initial begin
      #(8 * 20000);
      miscompares++;
      stop_test();
   end

   initial begin
      clk = 1'b0;
      sys_rst = 1'b1;
      tx_error_clear = 1'b0;
      mac_ready = 1'b1;
      miscompares = 0;
      n_compared = 0;
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      chk_bit("error after reset", 1'b0, tx_error_flag);
      // one skipped dword, lane 2 start, 16-byte alignment
      buf_tx(1, 1, 6, 7, 16, cmdb(16'ha5a5, 0, 0, 7), 8'h10);
      drain(16'ha5a5);
      // three buffers, middle one of four bytes, all alignments
      buf_tx(1, 0, 7, 5, 32, cmdb(16'h0102, 0, 0, 12), 8'h20);
      buf_tx(0, 0, 0, 4, 4, cmdb(16'h0102, 0, 0, 12), 8'h30);
      buf_tx(0, 1, 10, 3, 16, cmdb(16'h0102, 0, 0, 12), 8'h40);
      drain(16'h0102);
      chk_bit("error on good packet", 1'b0, tx_error_flag);
      // each start lane, paired with one of the four crc and pad settings
      for (int f = 0; f < 4; f++) begin
         buf_tx(1, 1, f, 5, 4, cmdb(16'h0c00, f[1], f[0], 5), 8'h60);
         drain(16'h0c00);
         chk_bit("add crc", !f[1] || f[0], mac_add_crc);
         chk_bit("add pad", !f[0], mac_add_pad);
      end
      // length mismatch, then traffic goes on with the flag held
      buf_tx(1, 1, 0, 6, 4, cmdb(16'h0bad, 0, 0, 7), 8'h50);
      drain(16'h0bad);
      chk_bit("error on length", 1'b1, tx_error_flag);
      buf_tx(1, 1, 3, 4, 4, cmdb(16'h0d0d, 0, 0, 4), 8'h70);
      drain(16'h0d0d);
      chk_bit("error held", 1'b1, tx_error_flag);
      clear_err();
      // second command word differs between buffers
      buf_tx(1, 0, 0, 4, 4, cmdb(16'h0e0e, 0, 0, 8), 8'h80);
      buf_tx(0, 1, 0, 4, 4, cmdb(16'h0e0e, 0, 1, 8), 8'h90);
      drain(16'h0e0e);
      chk_bit("error on cmd b", 1'b1, tx_error_flag);
      clear_err();
      // far side stalls: fifo fills and host is refused, then drains
      mac_ready <= 1'b0;
      fork
         buf_tx(1, 1, 31, 20, 32, cmdb(16'h0f0f, 0, 0, 20), 8'ha0);
         begin
            repeat (60) @(posedge clk);
            @(negedge clk);
            chk_bit("host refused when full", 1'b0, host_ready);
            @(posedge clk);
            mac_ready <= 1'b1;
         end
      join
      drain(16'h0f0f);
      chk_bit("error after stall", 1'b0, tx_error_flag);
      stop_test();
   end
endmodule : tx_buffer_command_parser_test
`default_nettype wire

// ==== tb/txbp_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ************************************************************
// host cpu writing command and data words
// ************************************************************
module txbp_host_model (
   input  wire logic   clk,
   input  wire logic   host_ready,
   output logic [31:0] host_data,
   output logic        host_valid
);
   initial begin
      host_data  = 32'h0000_0000;
      host_valid = 1'b0;
   end

   // word and valid stay put until ready is seen at an edge
   task automatic put(input logic [31:0] w);
      logic rdy;
      host_data  <= w;
      host_valid <= 1'b1;
      do begin
         @(negedge clk);
         rdy = host_ready;
         @(posedge clk);
      end while (!rdy);
   endtask : put

   // a released bus shows the inverse, never a stale word
   task automatic idle();
      host_valid <= 1'b0;
      host_data  <= ~host_data;
   endtask : idle

   // command a, command b, then data words with offset and filler
   task automatic send_buf(input logic fs, ls, input int ofs, size, al,
                           input logic [31:0] b, input logic [7:0] seed);
      int          n;
      logic [31:0] w;
      logic [1:0]  alc;
      alc = (al == 4) ? 2'h0 : (al == 16) ? 2'h1 : 2'h2;
      n   = (ofs + size + al - 1) / al * al; // host adds filler up to alignment
      put({6'h00, alc, 3'h0, 5'(ofs), 2'h0, fs, ls, 1'b0, 11'(size)});
      put(b);
      for (int i = 0; i < n; i += 4) begin
         for (int k = 0; k < 4; k++) begin
            w[8*k +: 8] = (i + k >= ofs && i + k < ofs + size) ?
                          seed + 8'(i + k - ofs) : 8'hee;
         end
         put(w);
      end
   endtask : send_buf
endmodule : txbp_host_model
`default_nettype wire
